/* File: logic/opt_shadow_map.svh */
// register offsets, field positions and reset values of the option shadow
// assumes a 32-bit apb slave with byte addresses
`ifndef OPT_SHADOW_MAP_SVH
`define OPT_SHADOW_MAP_SVH
// printed offset d0fh is not a multiple of four: kept as index, byte = 4*idx
`define SHADOW_IDX        12'hD0F
`define SHADOW_ADDR       14'h343C
// control register of our own: stop recovery bit 0 copy
`define STOPREC_IDX       12'hD10
`define STOPREC_ADDR      14'h3440
`define FLD_STACK         3
`define FLD_CLKDIV        2
`define FLD_LOWPROT       1
`define FLD_MAINPROT      0
`define STOPREC_RESET     1'b1
`define ADDR_W            14
`endif

/* File: logic/opt_shadow_pkg.sv */
// types shared by the option shadow block
// assumes nothing beyond the map header
package opt_shadow_pkg;
  // one-hot access grant verdict
  typedef enum logic [2:0] {
    GRANT_FULL  = 3'b001,
    GRANT_UPPER = 3'b010,
    GRANT_NONE  = 3'b100
  } grant_t;
endpackage

/* File: logic/option_byte_shadow_protect.sv */
// option byte shadow register with flash protection gating
// assumes stored option byte is stable at reset release and the flash
// controller pulses mass_erase_done_i on its own mclk_i domain
//
// Contract
// [RULE1] stack bit 0 gives full 16-bit stack addressing output
// [RULE2] clock divide 1 with stop recovery bit0 0 halves system clock
// [RULE3] both protect bits 1 give full main and page 3 access
// [RULE4] lower protect 0 blocks lower half and page 3 writes until erase
// [RULE5] main protect 1 permits main flash and page 3 access; code also needs lower protect 1 for lower half and page 3 writes
// [RULE6] main protect 0 blocks all main flash and page 3 writes
// [RULE7] mass erase sets shadow protect bits, stored bit unchanged
// [RULE8] after erase release, programmers may rewrite stored option bit
// [RULE9] reserved upper four bits read 0, writes ignored
// [RULE10] shadow at index d0f; stack and clock rw, protect read only
// [RULE11] reset loads shadow from stored byte, clock divide comes up 1
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`include "opt_shadow_map.svh"
module option_byte_shadow_protect (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // stored option byte and flash controller events
  input  wire logic [7:0]  stored_option_i,
  input  wire logic        mass_erase_done_i,
  // programming port access request
  input  wire logic        prog_req_i,
  input  wire logic        prog_lower_half_i,
  input  wire logic        prog_page3_write_i,
  // block outputs
  output logic             wide_stack_enable_o,
  output logic             sys_clock_half_o,
  output logic             prog_grant_o,
  output logic             option_rewrite_ok_o
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic       loaded;
  logic       wide_stack_enable;
  logic       clock_divide_select;
  logic       lower_half_protect;
  logic       main_flash_protect;
  logic       stop_recovery_bit0;
  logic       next_loaded;
  logic       next_wide_stack_enable;
  logic       next_clock_divide_select;
  logic       next_lower_half_protect;
  logic       next_main_flash_protect;
  logic       next_stop_recovery_bit0;
  logic [31:0] next_prdata;
  logic       next_pready;
  logic       next_pslverr;
  logic       next_grant;
  logic       next_half;
  logic       next_rewrite;
  opt_shadow_pkg::grant_t verdict;
  logic       acc;
  logic       hit_shadow;
  logic       hit_stop;
  logic [7:0] shadow_view;

  // word-aligned address match
  function automatic logic addr_is(input logic [31:0] a,
                                   input logic [13:0] b);
    addr_is = (a[31:14] == 18'h00000) && (a[13:0] == b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  always_comb begin
    acc        = psel_i && penable_i && !pready_o;
    hit_shadow = 1'b0;
    hit_stop   = 1'b0;
    if (addr_is(paddr_i, `SHADOW_ADDR)) begin
      hit_shadow = 1'b1;
    end else if (addr_is(paddr_i, `STOPREC_ADDR)) begin
      hit_stop = 1'b1;
    end
    // [RULE9] reserved read zero
    shadow_view = {4'h0, wide_stack_enable, clock_divide_select,
                   lower_half_protect, main_flash_protect};
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection verdict, a low bit stays closed until mass erase sets it
  always_comb begin
    // [RULE6] main protect closes all
    if (!main_flash_protect) begin
      verdict = opt_shadow_pkg::GRANT_NONE;
    // [RULE4] lower protect closes lower half
    end else if (!lower_half_protect) begin
      verdict = opt_shadow_pkg::GRANT_UPPER;
    // [RULE3] both set gives full access
    end else begin
      verdict = opt_shadow_pkg::GRANT_FULL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next values of shadow and bus answer
  always_comb begin
    next_loaded              = 1'b1;
    next_wide_stack_enable   = wide_stack_enable;
    next_clock_divide_select = clock_divide_select;
    next_lower_half_protect  = lower_half_protect;
    next_main_flash_protect  = main_flash_protect;
    next_stop_recovery_bit0  = stop_recovery_bit0;
    next_pready              = acc;
    next_pslverr             = acc && !hit_shadow && !hit_stop;
    next_prdata              = 32'h0000_0000;
    // [RULE11] load stored byte once after reset release
    if (!loaded) begin
      next_wide_stack_enable  = stored_option_i[`FLD_STACK];
      next_lower_half_protect = stored_option_i[`FLD_LOWPROT];
      next_main_flash_protect = stored_option_i[`FLD_MAINPROT];
    end else if (acc && pwrite_i && pstrb_i[0]) begin
      // [RULE10] cpu writes only stack and clock
      if (hit_shadow) begin
        next_wide_stack_enable   = pwdata_i[`FLD_STACK];
        next_clock_divide_select = pwdata_i[`FLD_CLKDIV];
      end else if (hit_stop) begin
        next_stop_recovery_bit0 = pwdata_i[0];
      end
    end
    // [RULE7] erase opens shadow only; wins over cpu writes, ignored before the load
    if (loaded && mass_erase_done_i) begin
      next_lower_half_protect = 1'b1;
      next_main_flash_protect = 1'b1;
    end
    if (acc && !pwrite_i) begin
      if (hit_shadow) begin
        next_prdata = {24'h00_0000, shadow_view};
      end else if (hit_stop) begin
        next_prdata = {31'h0000_0000, stop_recovery_bit0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived outputs
  always_comb begin
    // [RULE2] divide by two condition
    next_half = clock_divide_select && !stop_recovery_bit0;
    // [RULE5] grant per region
    case (verdict)
      opt_shadow_pkg::GRANT_FULL:  next_grant = prog_req_i;
      opt_shadow_pkg::GRANT_UPPER: next_grant = prog_req_i &&
                                   !prog_lower_half_i &&
                                   !prog_page3_write_i;
      default:                     next_grant = 1'b0;
    endcase
    // [RULE8] rewrite of stored bits only once fully open
    next_rewrite = (verdict == opt_shadow_pkg::GRANT_FULL);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loaded              <= 1'b0;
      wide_stack_enable   <= 1'b1;
      clock_divide_select <= 1'b1;
      lower_half_protect  <= 1'b0;
      main_flash_protect  <= 1'b0;
      stop_recovery_bit0  <= `STOPREC_RESET;
      pready_o            <= 1'b0;
      pslverr_o           <= 1'b0;
      prdata_o            <= 32'h0000_0000;
      wide_stack_enable_o <= 1'b0;
      sys_clock_half_o    <= 1'b0;
      prog_grant_o        <= 1'b0;
      option_rewrite_ok_o <= 1'b0;
    end else begin
      loaded              <= next_loaded;
      wide_stack_enable   <= next_wide_stack_enable;
      clock_divide_select <= next_clock_divide_select;
      lower_half_protect  <= next_lower_half_protect;
      main_flash_protect  <= next_main_flash_protect;
      stop_recovery_bit0  <= next_stop_recovery_bit0;
      pready_o            <= next_pready;
      pslverr_o           <= next_pslverr;
      prdata_o            <= next_prdata;
      // [RULE1] bit 0 means full stack addressing
      wide_stack_enable_o <= !wide_stack_enable;
      sys_clock_half_o    <= next_half;
      prog_grant_o        <= next_grant && loaded;
      option_rewrite_ok_o <= next_rewrite && loaded;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // [RULE7] erase opens both protect bits next cycle
  a_erase_opens: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    loaded && mass_erase_done_i |=> lower_half_protect && main_flash_protect)
    else $error("mass erase did not open shadow");
  // [RULE6] main protect low denies every request
  a_main_block: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !main_flash_protect && prog_req_i |=> !prog_grant_o)
    else $error("grant while main protect clear");
  // [RULE4] lower half blocked while lower protect low
  a_lower_block: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !lower_half_protect && prog_lower_half_i |=> !prog_grant_o)
    else $error("lower half granted while protected");
  // [RULE3] full access when both set
  a_full_open: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    loaded && lower_half_protect && main_flash_protect && prog_req_i
    |=> prog_grant_o)
    else $error("full access not granted");
  // [RULE5] upper access with main protect set
  a_main_open: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    loaded && main_flash_protect && prog_req_i && !prog_lower_half_i
    && !prog_page3_write_i |=> prog_grant_o)
    else $error("upper access not granted");
  // [RULE2] divide output follows its two causes
  a_clock_half: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sys_clock_half_o == $past(clock_divide_select && !stop_recovery_bit0))
    else $error("clock half mismatch");
  // [RULE1] stack output inverse of bit
  a_stack_wide: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $past(rstn_i) |-> wide_stack_enable_o == !$past(wide_stack_enable))
    else $error("stack enable mismatch");
  // [RULE9] reserved bits of read data zero
  a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    pready_o |-> prdata_o[7:4] == 4'h0)
    else $error("reserved bits not zero");
  // [RULE10] cpu write cannot change protect bits
  a_prot_readonly: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    loaded && !mass_erase_done_i |=> $stable(main_flash_protect)
    && $stable(lower_half_protect))
    else $error("protect bit changed by cpu");
  // [RULE8] rewrite allowed two cycles after a mass erase
  a_rewrite_ok: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    loaded && mass_erase_done_i |=> ##1 option_rewrite_ok_o)
    else $error("rewrite not allowed after erase");
  // [RULE11] clock divide comes up one
  a_reset_clock: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !loaded |-> clock_divide_select)
    else $error("clock divide not one at load");
endmodule // option_byte_shadow_protect

/* File: tb/prog_model.sv */
// partner model: external in-circuit flash programmer
// assumes the grant is registered one cycle after a request is taken
`timescale 1ns/1ns
module prog_model (
  // clock and grant from the device
  input  wire logic mclk_i,
  input  wire logic prog_grant_i,
  // request lines toward the device
  output logic      prog_req_o,
  output logic      prog_lower_half_o,
  output logic      prog_page3_write_o
);
  ////////////////////////////////////////////////////////////////////////
  // idle at time zero, no request pending
  initial begin
    prog_req_o         = 1'b0;
    prog_lower_half_o  = 1'b0;
    prog_page3_write_o = 1'b0;
  end
  // one access; qualifiers flip on release so stale values never match
  task automatic access(input logic lower, input logic page3,
                        output logic granted);
    @(posedge mclk_i);
    prog_req_o         <= 1'b1;
    prog_lower_half_o  <= lower;
    prog_page3_write_o <= page3;
    repeat (2) @(posedge mclk_i);
    granted            = prog_grant_i;
    prog_req_o         <= 1'b0;
    prog_lower_half_o  <= ~lower;
    prog_page3_write_o <= ~page3;
  endtask
endmodule // prog_model

/* File: tb/option_byte_shadow_protect_tb.sv */
// testbench of the option shadow block: apb master tasks, programmer model
// assumes the map header and a 20 MHz mclk_i
`timescale 1ns/1ns
`include "opt_shadow_map.svh"
module option_byte_shadow_protect_tb;
  logic        mclk_i, rstn_i, psel, penable, pwrite, erase_p, err, g;
  logic [31:0] paddr, pwdata, rd, prdata_o;
  logic [7:0]  stored;
  logic        pready_o, pslverr_o, stack_o, half_o, grant_o, rew_o;
  logic        req, lower, page3;
  int          n_errors, checks_done;
  ////////////////////////////////////////////////////////////////////////
  option_byte_shadow_protect dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .stored_option_i(stored), .mass_erase_done_i(erase_p),
    .prog_req_i(req), .prog_lower_half_i(lower),
    .prog_page3_write_i(page3), .wide_stack_enable_o(stack_o),
    .sys_clock_half_o(half_o), .prog_grant_o(grant_o),
    .option_rewrite_ok_o(rew_o));
  prog_model prog_u (.mclk_i(mclk_i), .prog_grant_i(grant_o),
    .prog_req_o(req), .prog_lower_half_o(lower),
    .prog_page3_write_o(page3));
  // 50 ns clock
  always #25 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge mclk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    check("read", rd, e);
  endtask
  // level outputs are registered twice behind the cause
  task automatic settle;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task automatic do_reset(input logic [7:0] v);
    rstn_i <= 1'b0;
    stored <= v;
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask
  // all four request kinds against the expected protection verdict
  task automatic grants(input logic m, l);
    for (int i = 0; i < 4; i++) begin
      prog_u.access(i[1], i[0], g);
      check("grant", 32'(g), 32'(m & (l | (i[1:0] == 2'b00))));
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_errors++;
    final_report();
  end
  // main sequence
  initial begin
    mclk_i = 1'b0; rstn_i = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0; erase_p = 1'b0;
    stored = 8'hF1;
    do_reset(8'hF1);
    rdc(`SHADOW_ADDR, 32'h05);
    check("stack", 32'(stack_o), 32'h1);
    $display("test reset done");
    apb(1'b1, `STOPREC_ADDR, 32'h0);
    settle();
    check("half", 32'(half_o), 32'h1);
    apb(1'b1, `SHADOW_ADDR, 32'hF0);
    rdc(`SHADOW_ADDR, 32'h01);
    settle();
    check("half", 32'(half_o), 32'h0);
    apb(1'b1, `SHADOW_ADDR, 32'h0C);
    rdc(`SHADOW_ADDR, 32'h0D);
    settle();
    check("stack", 32'(stack_o), 32'h0);
    rdc(32'h0, 32'h0);
    check("slverr", 32'(err), 32'h1);
    $display("test registers done");
    grants(1'b1, 1'b0);
    $display("test lower protect done");
    do_reset(8'hFC);
    rdc(`SHADOW_ADDR, 32'h0C);
    grants(1'b0, 1'b0);
    check("rewrite", 32'(rew_o), 32'h0);
    @(posedge mclk_i);
    erase_p <= 1'b1;
    @(posedge mclk_i);
    erase_p <= 1'b0;
    settle();
    check("rewrite", 32'(rew_o), 32'h1);
    rdc(`SHADOW_ADDR, 32'h0F);
    grants(1'b1, 1'b1);
    $display("test mass erase done");
    final_report();
  end
endmodule // option_byte_shadow_protect_tb
